// ==== src/mbidc_top.sv ====
// Memory bus interface with integrated DRAM controller
module mbidc_top (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Special function register port
  input wire logic i_sfr_we,
  input wire logic i_sfr_sel_high,
  input wire logic [7:0] i_sfr_wdata,
  output logic [7:0] o_mmr_base_high,
  output logic [7:0] o_mmr_base_low,
  // Core access port
  input wire mbidc_pkg::mbidc_req_type i_req,
  output logic o_ack,
  output logic [15:0] o_rdata,
  // External bus
  input wire logic [15:0] i_bus_data,
  output logic [15:0] o_bus_data,
  output logic o_bus_data_oe,
  output logic [11:0] o_bus_addr,
  output logic [5:0] o_chip_select_outputs_n,
  output logic o_cas_low_n,
  output logic o_cas_high_n,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic o_bus_reference_clock_out,
  output logic o_bus_reference_clock_out_oe
);
  // ----------------------------------------
  // Register state
  // ----------------------------------------
  logic [7:0] mmr_base_high_reg;
  logic [7:0] mmr_base_low_reg;
  logic [7:0] memory_interface_config_reg;
  logic [7:0] lock_reg;
  logic [7:0] refresh_timing_reg;
  logic [7:0] cfg_w [mbidc_pkg::NBANK];
  logic [7:0] am_w [mbidc_pkg::NBANK];
  logic [7:0] tmg_w [mbidc_pkg::NBANK];
  logic [5:0] hit_w;
  logic [5:0] we_cfg;
  logic [5:0] we_am;
  logic [5:0] we_tmg;
  logic mmr_hit;
  logic [11:0] mofs;
  logic unlocked;
  logic [11:0] bofs;
  logic [2:0] bidx;
  mbidc_pkg::mbidc_state_type state_reg;
  mbidc_pkg::mbidc_state_type state_next;
  assign mmr_hit = (i_req.addr[23:16] == mmr_base_high_reg) // R14
    && (i_req.addr[15:12] == mmr_base_low_reg[7:4]) && !i_req.data_space; // R15
  assign mofs = i_req.addr[11:0];
  assign unlocked = (lock_reg == mbidc_pkg::LOCK_KEY); // R16
  assign bofs = mofs - mbidc_pkg::OFS_BANK;
  assign bidx = bofs[4:2] < 3'd6 ? bofs[4:2] : 3'd7;
  // ----------------------------------------
  // Special function registers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mmr_base_high_reg <= mbidc_pkg::MMR_BASE_HIGH_RST;
      mmr_base_low_reg <= mbidc_pkg::MMR_BASE_LOW_RST;
    end else if (i_sfr_we) begin
      if (i_sfr_sel_high) begin
        mmr_base_high_reg <= i_sfr_wdata; // R14
      end else begin
        mmr_base_low_reg <= i_sfr_wdata; // R15
      end
    end
  end
  // ----------------------------------------
  // Memory mapped registers
  // ----------------------------------------
  logic mmr_wr;
  // Ack high means the held request was already served
  assign mmr_wr = i_req.req && i_req.wr && mmr_hit && !o_ack
    && state_reg == mbidc_pkg::MBIDC_IDLE;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      memory_interface_config_reg <= mbidc_pkg::MEMORY_INTERFACE_CONFIG_RST; // R13
      lock_reg <= 8'h0_000;
      refresh_timing_reg <= mbidc_pkg::REFRESH_TIMING_RST;
    end else if (mmr_wr) begin
      case (mofs)
        mbidc_pkg::OFS_MEMORY_INTERFACE_CONFIG: memory_interface_config_reg <= i_req.wdata[7:0]; // R13
        mbidc_pkg::OFS_LOCK: lock_reg <= i_req.wdata[7:0]; // R16
        mbidc_pkg::OFS_REFRESH_TIMING: refresh_timing_reg <= i_req.wdata[7:0]; // R20
        default: ;
      endcase
    end
  end
  always_comb begin
    we_cfg = '0;
    we_am = '0;
    we_tmg = '0;
    if (mmr_wr && mofs >= mbidc_pkg::OFS_BANK && bofs < 12'h0_018 && bidx != 3'd7) begin
      case (bofs[1:0])
        2'd0: we_cfg[bidx] = unlocked; // R16
        2'd1: we_am[bidx] = 1'b1;
        2'd2: we_tmg[bidx] = 1'b1;
        default: ;
      endcase
    end
  end
  // ----------------------------------------
  // Banks
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < mbidc_pkg::NBANK; g++) begin : gb
      mbidc_bank #(
        .CFG_INIT(g == 0 ? mbidc_pkg::CFG0_RST : mbidc_pkg::CFG_RST),
        .DRAM_OK(g != 0) // R09 R02
      ) u_bank (
        .i_ref_clk(i_ref_clk),
        .i_nrst(i_nrst),
        .i_we_cfg(we_cfg[g]),
        .i_we_am(we_am[g]),
        .i_we_tmg(we_tmg[g]),
        .i_wdata(i_req.wdata[7:0]),
        .i_addr(i_req.addr),
        .o_cfg(cfg_w[g]),
        .o_am(am_w[g]),
        .o_tmg(tmg_w[g]),
        .o_hit(hit_w[g])
      );
    end
  endgenerate
  // Lowest hitting bank wins; data space only keeps a request off the register space
  logic [2:0] sel;
  logic any_hit;
  always_comb begin
    sel = 3'd0;
    any_hit = 1'b0;
    for (int i = mbidc_pkg::NBANK - 1; i >= 0; i--) begin
      if (hit_w[i]) begin
        sel = 3'(i);
        any_hit = 1'b1;
      end
    end
  end
  // ----------------------------------------
  // Refresh timer
  // ----------------------------------------
  logic [11:0] rf_cnt_reg;
  logic rf_pend_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rf_cnt_reg <= 12'h0_000;
      rf_pend_reg <= 1'b0;
    end else if (!refresh_timing_reg[mbidc_pkg::REFRESH_TIMING_EN]) begin
      rf_cnt_reg <= 12'h0_000; // R20
      rf_pend_reg <= 1'b0;
    end else begin
      if (rf_cnt_reg >= {refresh_timing_reg[6:0], mbidc_pkg::REFRESH_TIMING_SCALE}) begin
        rf_cnt_reg <= 12'h0_000;
        rf_pend_reg <= 1'b1; // R03
      end else begin
        rf_cnt_reg <= rf_cnt_reg + 12'h0_001;
      end
      if (state_reg == mbidc_pkg::MBIDC_REF) begin
        rf_pend_reg <= 1'b0;
      end
    end
  end
  // ----------------------------------------
  // Bus cycle sequencer
  // ----------------------------------------
  logic [3:0] wait_reg;
  logic [2:0] cur_reg;
  logic half_reg;
  logic cur_dram;
  logic cur_w16;
  logic ext_req;
  assign cur_dram = cfg_w[cur_reg][mbidc_pkg::CFG_DRAM];
  assign cur_w16 = cfg_w[cur_reg][mbidc_pkg::CFG_W16];
  assign ext_req = i_req.req && !mmr_hit && any_hit;
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mbidc_pkg::MBIDC_IDLE: begin
        if (rf_pend_reg) begin
          state_next = mbidc_pkg::MBIDC_REF;
        end else if (ext_req) begin
          state_next = cfg_w[sel][mbidc_pkg::CFG_DRAM] ? mbidc_pkg::MBIDC_ROW
                                                     : mbidc_pkg::MBIDC_GEN;
        end
      end
      mbidc_pkg::MBIDC_ROW: if (wait_reg == 4'h0_000) state_next = mbidc_pkg::MBIDC_COL;
      mbidc_pkg::MBIDC_COL: if (wait_reg == 4'h0_000) state_next = mbidc_pkg::MBIDC_PRE;
      mbidc_pkg::MBIDC_GEN: begin
        if (wait_reg == 4'h0_000) begin
          state_next = (!cur_w16 && !half_reg) ? mbidc_pkg::MBIDC_GEN // R10
                                               : mbidc_pkg::MBIDC_PRE;
        end
      end
      mbidc_pkg::MBIDC_REF: if (wait_reg == 4'h0_000) state_next = mbidc_pkg::MBIDC_PRE;
      mbidc_pkg::MBIDC_PRE: state_next = mbidc_pkg::MBIDC_IDLE;
      default: state_next = mbidc_pkg::MBIDC_IDLE;
    endcase
  end
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      state_reg <= mbidc_pkg::MBIDC_IDLE;
      wait_reg <= 4'h0_000;
      cur_reg <= 3'd0;
      half_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      if (state_reg == mbidc_pkg::MBIDC_IDLE) begin
        cur_reg <= sel;
        half_reg <= 1'b0;
        wait_reg <= rf_pend_reg ? mbidc_pkg::REFRESH_TIMING_LEN : tmg_w[sel][7:4];
      end else if (wait_reg != 4'h0_000) begin
        wait_reg <= wait_reg - 4'h0_001;
      end else begin
        wait_reg <= tmg_w[cur_reg][3:0]; // R19
        if (state_reg == mbidc_pkg::MBIDC_GEN) begin
          half_reg <= 1'b1;
        end
      end
    end
  end
  // ----------------------------------------
  // Pin drivers, all registered except the reference clock, which is the XOR of two flops
  // ----------------------------------------
  logic [22:0] dram_addr;
  logic [3:0] mux_sh;
  assign dram_addr = i_req.addr[22:0];
  assign mux_sh = {2'b00, am_w[cur_reg][5]} + 4'd9; // R03
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_chip_select_outputs_n <= 6'h0_03f;
      o_cas_low_n <= 1'b1;
      o_cas_high_n <= 1'b1;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      o_bus_addr <= 12'h0_000;
      o_bus_data <= 16'h0_000;
      o_bus_data_oe <= 1'b0;
      o_ack <= 1'b0;
      o_rdata <= 16'h0_000;
    end else begin
      o_chip_select_outputs_n <= 6'h0_03f;
      o_cas_low_n <= 1'b1;
      o_cas_high_n <= 1'b1;
      o_ack <= 1'b0;
      o_bus_data_oe <= 1'b0;
      o_rd_n <= 1'b1;
      o_wr_n <= 1'b1;
      case (state_next)
        mbidc_pkg::MBIDC_ROW, mbidc_pkg::MBIDC_GEN, mbidc_pkg::MBIDC_COL: begin
          if (cfg_w[cur_reg][mbidc_pkg::CFG_EN] || state_reg == mbidc_pkg::MBIDC_IDLE) begin
            o_chip_select_outputs_n[state_reg == mbidc_pkg::MBIDC_IDLE ? sel : cur_reg]
              <= 1'b0; // R01 R21
          end
          // R07: MEMORY_INTERFACE_CONFIG bit1 picks strobe pair or data strobe plus direction
          if (memory_interface_config_reg[mbidc_pkg::MEMORY_INTERFACE_CONFIG_STRB]) begin
            o_rd_n <= 1'b0;
            o_wr_n <= !i_req.wr;
          end else begin
            o_rd_n <= i_req.wr;
            o_wr_n <= !i_req.wr;
          end
          o_bus_data_oe <= i_req.wr;
          o_bus_data <= i_req.wdata;
          if (state_next == mbidc_pkg::MBIDC_ROW) begin
            o_bus_addr <= 12'(dram_addr >> mux_sh);
          end else if (state_next == mbidc_pkg::MBIDC_COL) begin
            o_bus_addr <= 12'(dram_addr[12:1]);
            o_cas_low_n <= 1'b0; // R03
            o_cas_high_n <= 1'b0;
          end else begin
            o_bus_addr <= {i_req.addr[11:1], half_reg}; // R10
          end
        end
        mbidc_pkg::MBIDC_REF: begin
          o_cas_low_n <= 1'b0;
          o_cas_high_n <= 1'b0;
          for (int i = 1; i < mbidc_pkg::NBANK; i++) begin
            if (cfg_w[i][mbidc_pkg::CFG_EN] && cfg_w[i][mbidc_pkg::CFG_DRAM]) begin
              o_chip_select_outputs_n[i] <= wait_reg > 4'h0_002 ? 1'b1 : 1'b0; // R03
            end
          end
        end
        default: ;
      endcase
      if (state_reg != mbidc_pkg::MBIDC_IDLE && state_next == mbidc_pkg::MBIDC_PRE
          && state_reg != mbidc_pkg::MBIDC_REF) begin
        o_ack <= 1'b1;
        if (cur_w16 || cur_dram) begin
          o_rdata <= i_bus_data; // R10
        end else begin
          o_rdata <= {i_bus_data[7:0], o_rdata[15:8]};
        end
      end else if (state_reg == mbidc_pkg::MBIDC_GEN && wait_reg == 4'h0_000) begin
        o_rdata <= {i_bus_data[7:0], o_rdata[15:8]};
      end else if (i_req.req && mmr_hit && !o_ack && state_reg == mbidc_pkg::MBIDC_IDLE) begin
        o_ack <= 1'b1;
        o_rdata <= {8'h0_000, memory_interface_config_reg};
      end
    end
  end
  // Reference clock enable follows MEMORY_INTERFACE_CONFIG bit0 through the pin register stage
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_bus_reference_clock_out_oe <= 1'b1;
    end else begin
      o_bus_reference_clock_out_oe <= memory_interface_config_reg[mbidc_pkg::MEMORY_INTERFACE_CONFIG_CLKEN]; // R13
    end
  end
  // Rise flop toggles, fall flop follows; their difference is the clock
  logic clk_rise_reg;
  logic clk_fall_reg;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_rise_reg <= 1'b0;
    end else begin
      clk_rise_reg <= !clk_rise_reg;
    end
  end
  always_ff @(negedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      clk_fall_reg <= 1'b0;
    end else begin
      clk_fall_reg <= clk_rise_reg;
    end
  end
  assign o_bus_reference_clock_out = clk_rise_reg ^ clk_fall_reg; // R12
  assign o_mmr_base_high = mmr_base_high_reg;
  assign o_mmr_base_low = mmr_base_low_reg;
endmodule

// ==== src/mbidc_pkg.sv ====
// Package for the memory bus interface with DRAM controller
// Behaviour
// R01: Select pin is chip select or row strobe
// R02: Six selects, five usable as row strobes
// R03: Block makes column strobe, muxing and refresh
// R04: DRAM bank spans 8MB, EDO or FPM
// R05: Total DRAM 16MB, or 32MB split
// R06: Generic bank decodes 1MB, six give 6MB
// R07: Separate strobes or data strobe plus direction
// R08: Each bank has its own programmable settings
// R09: First select always generic, boot device
// R10: Every external read is sixteen bits wide; 8-bit generic banks are read as two byte cycles, low byte first
// R11: Byte FIFOs sit on 16-bit bus, one lane
// R12: Reference clock follows system clock, aligned
// R13: Reference clock enabled at reset, software disables
// R14: Register space 4KB, high base byte
// R15: Low base register gives bits 15 to 12
// R16: Lock register guards bank configuration writes
// R17: Per-bank 8-bit configuration register
// R18: Per-bank base address and mux register
// R19: Per-bank 8-bit timing register
// R20: Refresh register holds interval and enable
// R21: Disabled bank never asserts its select
package mbidc_pkg;
  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NBANK = 6;
  localparam int ADDR_W = 25;
  localparam int MA_W = 12;
  // ----------------------------------------
  // Register offsets within the 4KB space
  // ----------------------------------------
  localparam logic [11:0] OFS_MEMORY_INTERFACE_CONFIG = 12'h0_000;
  localparam logic [11:0] OFS_LOCK = 12'h0_001;
  localparam logic [11:0] OFS_REFRESH_TIMING = 12'h0_002;
  localparam logic [11:0] OFS_BANK = 12'h0_010;
  localparam logic [11:0] OFS_BANK_STRIDE = 12'h0_004;
  localparam logic [7:0] LOCK_KEY = 8'h0_0a5;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int MEMORY_INTERFACE_CONFIG_CLKEN = 0;
  localparam int MEMORY_INTERFACE_CONFIG_STRB = 1;
  localparam int CFG_EN = 7;
  localparam int CFG_DRAM = 6;
  localparam int CFG_W16 = 5;
  localparam int CFG_EDO = 4;
  localparam int REFRESH_TIMING_EN = 7;
  localparam logic [7:0] MEMORY_INTERFACE_CONFIG_RST = 8'h0_001;
  localparam logic [7:0] CFG0_RST = 8'h0_0a0;
  localparam logic [7:0] CFG_RST = 8'h0_000;
  localparam logic [7:0] TMG_RST = 8'h0_00f;
  localparam logic [7:0] REFRESH_TIMING_RST = 8'h0_000;
  localparam logic [7:0] MMR_BASE_HIGH_RST = 8'h0_000;
  localparam logic [7:0] MMR_BASE_LOW_RST = 8'h0_000;
  localparam logic [4:0] REFRESH_TIMING_SCALE = 5'h0_010;
  localparam logic [3:0] REFRESH_TIMING_LEN = 4'h0_004;
  typedef enum logic [2:0] {
    MBIDC_IDLE = 3'b000,
    MBIDC_ROW = 3'b001,
    MBIDC_COL = 3'b010,
    MBIDC_GEN = 3'b011,
    MBIDC_REF = 3'b100,
    MBIDC_PRE = 3'b101
  } mbidc_state_type;
  typedef struct packed {
    logic req;
    logic wr;
    logic data_space;
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
  } mbidc_req_type;
  typedef struct packed {
    logic rd_n;
    logic wr_n;
    logic ds_n;
    logic rw;
  } mbidc_strb_type;
endpackage

// ==== src/mbidc_bank.sv ====
// One bank: register set and address decode
module mbidc_bank #(
  parameter logic [7:0] CFG_INIT = 8'h0_000,
  parameter bit DRAM_OK = 1'b1
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Register writes
  input wire logic i_we_cfg,
  input wire logic i_we_am,
  input wire logic i_we_tmg,
  input wire logic [7:0] i_wdata,
  // Decode
  input wire logic [24:0] i_addr,
  output logic [7:0] o_cfg,
  output logic [7:0] o_am,
  output logic [7:0] o_tmg,
  output logic o_hit
);
  logic [7:0] cfg_reg;
  logic [7:0] am_reg;
  logic [7:0] tmg_reg;
  logic is_dram;
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_reg <= CFG_INIT;
      am_reg <= 8'h0_000;
      tmg_reg <= mbidc_pkg::TMG_RST;
    end else begin
      if (i_we_cfg) begin // R17 R08
        cfg_reg <= i_wdata;
        if (!DRAM_OK) begin
          cfg_reg[mbidc_pkg::CFG_DRAM] <= 1'b0; // R09
        end
      end
      if (i_we_am) begin
        am_reg <= i_wdata; // R18
      end
      if (i_we_tmg) begin
        tmg_reg <= i_wdata; // R19
      end
    end
  end
  assign is_dram = cfg_reg[mbidc_pkg::CFG_DRAM];
  // DRAM decodes 8MB on am[7:6]; generic decodes 1MB on am[4:0]
  always_comb begin
    if (!cfg_reg[mbidc_pkg::CFG_EN]) begin
      o_hit = 1'b0; // R21
    end else if (is_dram) begin
      o_hit = (i_addr[24:23] == am_reg[7:6]); // R04 R05
    end else begin
      o_hit = (i_addr[24:20] == am_reg[4:0]); // R06
    end
  end
  assign o_cfg = cfg_reg;
  assign o_am = am_reg;
  assign o_tmg = tmg_reg;
endmodule

// ==== tb/mbidc_assertions.sv ====
// Port checker for the memory bus interface
module mbidc_assertions (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // Watched ports
  input wire logic i_sfr_we,
  input wire logic i_sfr_sel_high,
  input wire logic [7:0] i_sfr_wdata,
  input wire mbidc_pkg::mbidc_req_type i_req,
  input wire logic [7:0] o_mmr_base_high,
  input wire logic [7:0] o_mmr_base_low,
  input wire logic [5:0] o_chip_select_outputs_n,
  input wire logic o_cas_low_n,
  input wire logic o_cas_high_n,
  input wire logic o_rd_n,
  input wire logic o_bus_data_oe,
  input wire logic o_bus_reference_clock_out_oe
);
  // ----------
  // Properties
  // ----------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);
  sequence s_high_write;
    i_sfr_we && i_sfr_sel_high;
  endsequence
  property p_reset_state;
    $rose(i_nrst) |-> (&o_chip_select_outputs_n) && o_bus_reference_clock_out_oe && !o_bus_data_oe;
  endproperty
  property p_base_high;
    s_high_write |=> o_mmr_base_high == $past(i_sfr_wdata);
  endproperty
  property p_base_low;
    i_sfr_we && !i_sfr_sel_high |=> o_mmr_base_low[7:4] == $past(i_sfr_wdata[7:4]);
  endproperty
  property p_base_hold;
    !i_sfr_we |=> $stable(o_mmr_base_high) && $stable(o_mmr_base_low);
  endproperty
  property p_boot_no_cas;
    !o_chip_select_outputs_n[0] |-> o_cas_low_n && o_cas_high_n;
  endproperty
  property p_cas_pair;
    !o_rd_n && !o_cas_low_n |-> !o_cas_high_n;
  endproperty
  property p_multi_sel;
    !$onehot0(~o_chip_select_outputs_n) |-> !o_cas_low_n;
  endproperty
  property p_bus_reference_clock_out_off;
    $fell(o_bus_reference_clock_out_oe) |-> $past(i_req.req && i_req.wr);
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bus busy after reset");
  a_base_high: assert property (p_base_high) else $error("high base not loaded");
  a_base_low: assert property (p_base_low) else $error("low base not loaded");
  a_base_hold: assert property (p_base_hold) else $error("base moved unasked");
  a_boot_no_cas: assert property (p_boot_no_cas) else $error("column strobe on boot");
  a_cas_pair: assert property (p_cas_pair) else $error("read not word wide");
  a_multi_sel: assert property (p_multi_sel) else $error("several selects");
  a_bus_reference_clock_out_off: assert property (p_bus_reference_clock_out_off) else $error("clock output lost");
endmodule
bind mbidc_top mbidc_assertions mbidc_assertions_inst (
  .i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_sfr_we(i_sfr_we),
  .i_sfr_sel_high(i_sfr_sel_high), .i_sfr_wdata(i_sfr_wdata), .i_req(i_req),
  .o_mmr_base_high(o_mmr_base_high), .o_mmr_base_low(o_mmr_base_low),
  .o_chip_select_outputs_n(o_chip_select_outputs_n), .o_cas_low_n(o_cas_low_n),
  .o_cas_high_n(o_cas_high_n), .o_rd_n(o_rd_n), .o_bus_data_oe(o_bus_data_oe),
  .o_bus_reference_clock_out_oe(o_bus_reference_clock_out_oe)
);

// ==== tb/mbidc_mem_model.sv ====
// Word-wide external memory on the select bus
module mbidc_mem_model (
  // Bus from the controller
  input wire logic i_ref_clk,
  input wire logic [5:0] i_cs_n,
  input wire logic i_rd_n,
  input wire logic i_wr_n,
  input wire logic [11:0] i_addr,
  input wire logic [15:0] i_data,
  // Read data
  output logic [15:0] o_data
);
  logic [15:0] mem [4096];
  logic [15:0] last_reg;
  logic rd;
  assign rd = !(&i_cs_n) && !i_rd_n && i_wr_n;
  always_ff @(posedge i_ref_clk) begin
    if (!(&i_cs_n) && !i_wr_n)
      mem[i_addr] <= i_data;
    if (rd)
      last_reg <= mem[i_addr];
  end
  // Released bus shows the inverse, never a stale word
  assign o_data = rd ? mem[i_addr] : ~last_reg;
endmodule

// ==== tb/mbidc_top_tb.sv ====
// Self-checking bench for the memory bus interface
module mbidc_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  // -------
  // Signals
  // -------
  localparam logic [24:0] MEMORY_MAPPED_REGISTER_SPACE = 25'h012_3000;
  logic clk = 1'b0, nrst = 1'b0, we = 1'b0, hi = 1'b0, ok, rd_n, wr_n, cas_l, ack, ckoe;
  logic [7:0] wd = 8'h00, mhi, mlo, mon = 8'h00;
  logic [11:0] ba;
  logic [15:0] bin, bout, rdata, q;
  logic [5:0] cs_n;
  mbidc_pkg::mbidc_req_type req = '0;
  int err_total = 0, tests_run = 0;
  mbidc_top mbidc_top_inst (
    .i_ref_clk(clk), .i_nrst(nrst), .i_sfr_we(we), .i_sfr_sel_high(hi),
    .i_sfr_wdata(wd), .o_mmr_base_high(mhi), .o_mmr_base_low(mlo), .i_req(req),
    .o_ack(ack), .o_rdata(rdata), .i_bus_data(bin), .o_bus_data(bout),
    .o_bus_data_oe(), .o_bus_addr(ba), .o_chip_select_outputs_n(cs_n),
    .o_cas_low_n(cas_l), .o_cas_high_n(), .o_rd_n(rd_n), .o_wr_n(wr_n),
    .o_bus_reference_clock_out(), .o_bus_reference_clock_out_oe(ckoe)
  );
  mbidc_mem_model mbidc_mem_model_inst (
    .i_ref_clk(clk), .i_cs_n(cs_n), .i_rd_n(rd_n), .i_wr_n(wr_n),
    .i_addr(ba), .i_data(bout), .o_data(bin)
  );
  always #20 clk = ~clk;
  // Sticky: both strobes low, column strobe, selects
  always @(posedge clk) mon <= mon | {~rd_n & ~wr_n, ~cas_l, ~cs_n};
  task chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    tests_run++;
    if (s !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, s);
    end
  endtask
  task give_verdict;
    if (err_total == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic acc(input logic w, input logic [24:0] a, input logic [15:0] d);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge clk);
    req <= '{1'b1, w, 1'b0, a, d};
    while (!ok && n < 60) begin
      @(negedge clk);
      ok = (ack === 1'b1);
      q = rdata;
      n++;
    end
    @(posedge clk);
    req <= '0;
  endtask
  task wreg(input logic [11:0] o, input logic [7:0] v);
    acc(1'b1, MEMORY_MAPPED_REGISTER_SPACE + 25'(o), {8'h00, v});
  endtask
  task wbank(input int i, input int f, input logic [7:0] v);
    wreg(12'(mbidc_pkg::OFS_BANK + i * mbidc_pkg::OFS_BANK_STRIDE + f), v);
  endtask
  task wcfg(input int i, input logic [7:0] v);
    wreg(mbidc_pkg::OFS_LOCK, mbidc_pkg::LOCK_KEY);
    wbank(i, 0, v);
  endtask
  task clr;
    @(negedge clk);
    mon = 8'h00;
  endtask
  task t_reset;
    @(posedge clk);
    nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk("selects", 16'(cs_n), 16'h003f);
    chk("bus_reference_clock_out enable", 16'(ckoe), 16'h0001);
    chk("base high", 16'(mhi), 16'(mbidc_pkg::MMR_BASE_HIGH_RST));
    acc(1'b0, 25'h000_0000, 16'h0000);
    chk("config", 16'(q[7:0]), 16'(mbidc_pkg::MEMORY_INTERFACE_CONFIG_RST));
  endtask
  task t_base;
    @(posedge clk);
    we <= 1'b1;
    hi <= 1'b1;
    wd <= MEMORY_MAPPED_REGISTER_SPACE[23:16];
    @(posedge clk);
    hi <= 1'b0;
    wd <= {MEMORY_MAPPED_REGISTER_SPACE[15:12], 4'h0};
    @(posedge clk);
    we <= 1'b0;
    @(negedge clk);
    chk("base high", 16'(mhi), 16'(MEMORY_MAPPED_REGISTER_SPACE[23:16]));
    chk("base low", 16'(mlo[7:4]), 16'(MEMORY_MAPPED_REGISTER_SPACE[15:12]));
    acc(1'b0, MEMORY_MAPPED_REGISTER_SPACE, 16'h0000);
    chk("moved ack", 16'(ok), 16'h0001);
  endtask
  task t_generic;
    clr;
    acc(1'b1, 25'h000_0100, 16'hbeef);
    acc(1'b0, 25'h000_0100, 16'h0000);
    chk("generic data", q, 16'hbeef);
    chk("boot strobes", 16'(mon), 16'h0001);
  endtask
  task t_lock;
    wbank(1, 1, 8'h02);
    wbank(1, 0, 8'ha0);
    clr;
    acc(1'b0, 25'h020_0000, 16'h0000);
    chk("locked bank", 16'({ok, mon[1]}), 16'h0000);
    wcfg(1, 8'ha0);
    clr;
    acc(1'b1, 25'h020_0000, 16'h1357);
    chk("open bank", 16'({ok, mon[1]}), 16'h0003);
    wcfg(1, 8'h20);
    clr;
    acc(1'b0, 25'h020_0000, 16'h0000);
    chk("off bank", 16'({ok, mon[1]}), 16'h0000);
  endtask
  task t_dram;
    wbank(2, 1, 8'h40);
    wcfg(2, 8'he0);
    clr;
    acc(1'b1, 25'h080_0000, 16'h2468);
    acc(1'b0, 25'h080_0000, 16'h0000);
    chk("dram data", q, 16'h2468);
    chk("row and column", 16'(mon[6:0]), 16'h0044);
    wreg(mbidc_pkg::OFS_REFRESH_TIMING, 8'h81);
    clr;
    repeat (120) @(posedge clk);
    chk("refresh", 16'(mon[6]), 16'h0001);
    wreg(mbidc_pkg::OFS_REFRESH_TIMING, 8'h00);
  endtask
  task t_strobe;
    wreg(mbidc_pkg::OFS_MEMORY_INTERFACE_CONFIG, 8'h02);
    @(negedge clk);
    chk("bus_reference_clock_out off", 16'(ckoe), 16'h0000);
    clr;
    acc(1'b1, 25'h000_0200, 16'h5a5a);
    acc(1'b0, 25'h000_0200, 16'h0000);
    chk("data strobe", 16'(mon[7]), 16'h0001);
    chk("strobe data", q, 16'h5a5a);
    wreg(mbidc_pkg::OFS_MEMORY_INTERFACE_CONFIG, 8'h01);
    @(negedge clk);
    chk("bus_reference_clock_out on", 16'(ckoe), 16'h0001);
  endtask
  // Whole run is under 500 cycles
  initial begin
    #800000;
    err_total++;
    give_verdict;
  end
  initial begin
    t_reset;
    t_base;
    t_generic;
    t_lock;
    t_dram;
    t_strobe;
    t_reset;
    give_verdict;
  end
endmodule
